//--- logic/buck3_defines.svh
// offsets, field positions, reset values and timing counts of the buck3 control register
// assumes inclusion by bare name from any file of the block
`ifndef BUCK3_DEFINES_SVH
`define BUCK3_DEFINES_SVH

// register subaddress on the serial control interface
`define BUCK3_ADDR          8'h18
// unused byte value with the pulse-skip bit clear; the register resets to 9Fh
`define BUCK3_RESET         8'h1F
// field positions
`define BUCK3_PSE_BIT       7
`define BUCK3_RSV_BIT       6
`define BUCK3_CODE_MSB      5
`define BUCK3_CODE_LSB      0
// field reset values
`define BUCK3_PSE_RESET     1'b1
`define BUCK3_CODE_RESET    6'h1F
// monitor blanking time after a write, and the clock rate
`define BUCK3_BLANK_MS      5
`define BUCK3_CLOCK_KHZ     250000
`define BUCK3_BLANK_CYCLES  (`BUCK3_BLANK_MS * `BUCK3_CLOCK_KHZ)
// width of the blanking counter, enough for the full count
`define BUCK3_BLANK_W       21

`endif

//--- logic/buck3_pkg.sv
// types shared by the buck3 control register files
// assumes buck3_defines.svh for the numbers
package buck3_pkg;

  // 6-bit output-voltage code, 0.900 V at code 0 up to 3.400 V at code 3F
  typedef logic [5:0] voltage_code_t;

  // power-up sequence of the register: catch the default select, then run
  typedef enum logic {
    ST_CATCH,
    ST_RUN
  } init_state_t;

endpackage

//--- logic/blank_timer.sv
// restartable one-shot timer that holds its output for a fixed count of cycles
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/10ps
`include "buck3_defines.svh"

module blank_timer #(
  parameter int COUNT = `BUCK3_BLANK_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic restart,
  // state
  output logic      blank
);
  logic [`BUCK3_BLANK_W-1:0] count;
  wire                       at_end = (count == `BUCK3_BLANK_W'(COUNT - 1));

  // restart wins; otherwise count out the interval and drop blank
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      blank <= 1'b0;
    end else if (restart) begin
      count <= '0;
      blank <= 1'b1;
    end else if (blank) begin
      count <= at_end ? count : count + 1'b1;
      blank <= !at_end;
    end
  end
endmodule

//--- logic/buck3_voltage_control_reg.sv
// control register of the third step-down converter: pulse-skip enable and voltage code
// assumes the serial interface decodes a subaddress and strobes one-cycle read and write
// requests on CLOCK, and the password logic raises WRITE_UNLOCK for a permitted write;
// DEFAULT_SELECT_CODE is a settled level on CLOCK by the time reset is released
//
// Function
// - register answers at subaddress 18h and resets to value 9Fh
// - writes take effect only when unlocked by the password procedure
// - any performed write blanks over and undervoltage monitoring for 5 ms
// - power-up voltage code follows the sensed default-select resistor setting
// - bit 7 pulse-skip enable, reset 1; 0 forces fixed-frequency operation
// - bits 5..0 voltage code, 0 is 0.900 V, 3F is 3.400 V
`timescale 1ns/10ps
`include "buck3_defines.svh"

module buck3_voltage_control_reg #(
  parameter int BLANK_CYCLES = `BUCK3_BLANK_CYCLES
) (
  // clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 SYS_RST,
  // register access from the serial control interface
  input  wire logic [7:0]           REG_ADDR,
  input  wire logic [7:0]           REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [7:0]           REG_RDATA,
  output logic                      REG_RVALID,
  // password protection
  input  wire logic                 WRITE_UNLOCK,
  output logic                      WRITE_REFUSED,
  // sensed power-up default from the default-select resistor
  input  wire buck3_pkg::voltage_code_t DEFAULT_SELECT_CODE,
  // converter controls
  output logic                      PULSE_SKIP_ENABLE,
  output buck3_pkg::voltage_code_t  BUCK3_VOLTAGE_CODE,
  output logic                      MONITOR_BLANK
);
  // power-up sequence state
  buck3_pkg::init_state_t state;
  buck3_pkg::init_state_t next_state;

  // address decode and write qualification
  wire hit        = (REG_ADDR == `BUCK3_ADDR);
  wire catching   = (state == buck3_pkg::ST_CATCH);
  wire wr_hit     = REG_WR && hit && (state == buck3_pkg::ST_RUN);
  wire wr_accept  = wr_hit && WRITE_UNLOCK;
  wire wr_refuse  = wr_hit && !WRITE_UNLOCK;
  wire rd_hit     = REG_RD && hit;

  // read image: reserved bit forced to zero
  wire [7:0] read_image = {PULSE_SKIP_ENABLE, 1'b0, BUCK3_VOLTAGE_CODE};
  wire [7:0] next_rdata = rd_hit ? read_image : 8'h00;

  // power-up sequence: one cycle to catch the sensed default after release
  always_comb begin
    next_state = state;
    unique case (state)
      buck3_pkg::ST_CATCH: next_state = buck3_pkg::ST_RUN;
      buck3_pkg::ST_RUN:   next_state = buck3_pkg::ST_RUN;
    endcase
  end

  // state register: catch once after release, then run
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= buck3_pkg::ST_CATCH;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PULSE_SKIP_ENABLE <= `BUCK3_PSE_RESET;
    end else if (wr_accept) begin
      PULSE_SKIP_ENABLE <= REG_WDATA[`BUCK3_PSE_BIT];
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BUCK3_VOLTAGE_CODE <= `BUCK3_CODE_RESET;
    end else if (state == buck3_pkg::ST_CATCH) begin
      BUCK3_VOLTAGE_CODE <= DEFAULT_SELECT_CODE;
    end else if (wr_accept) begin
      BUCK3_VOLTAGE_CODE <= REG_WDATA[`BUCK3_CODE_MSB:`BUCK3_CODE_LSB];
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA     <= 8'h00;
      REG_RVALID    <= 1'b0;
      WRITE_REFUSED <= 1'b0;
    end else begin
      REG_RDATA     <= next_rdata;
      REG_RVALID    <= rd_hit;
      WRITE_REFUSED <= wr_refuse;
    end
  end

  blank_timer #(
    .COUNT   (BLANK_CYCLES)
  ) u_blank (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .restart (wr_accept),
    .blank   (MONITOR_BLANK)
  );

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  // length of the current blanking interval, for the checks
  logic [`BUCK3_BLANK_W-1:0] blank_len;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      blank_len <= '0;
    end else if (wr_accept) begin
      blank_len <= '0;
    end else if (MONITOR_BLANK) begin
      blank_len <= blank_len + 1'b1;
    end
  end

  sequence s_accepted_write;
    REG_WR && hit && WRITE_UNLOCK && (state == buck3_pkg::ST_RUN);
  endsequence

  sequence s_blank_held;
    MONITOR_BLANK [*4];
  endsequence

  chk_read_answer: assert property (
    rd_hit |=> REG_RVALID && (REG_RDATA == {$past(PULSE_SKIP_ENABLE), 1'b0, $past(BUCK3_VOLTAGE_CODE)}))
    else $error("read of the control register returned a wrong value");

  chk_other_addr_write: assert property (
    (REG_WR && !hit && !catching) |=> $stable(BUCK3_VOLTAGE_CODE) && $stable(PULSE_SKIP_ENABLE))
    else $error("write to another subaddress changed the register");

  chk_locked_write: assert property (
    wr_refuse |=> WRITE_REFUSED && $stable(BUCK3_VOLTAGE_CODE) && $stable(PULSE_SKIP_ENABLE))
    else $error("locked write changed the register or was not flagged");

  chk_blank_start: assert property (
    s_accepted_write |=> s_blank_held)
    else $error("monitor blanking did not start and hold after a write");

  chk_blank_length: assert property (
    $fell(MONITOR_BLANK) |-> (blank_len == `BUCK3_BLANK_W'(BLANK_CYCLES)))
    else $error("monitor blanking ended at the wrong time");

  chk_default_catch: assert property (
    (state == buck3_pkg::ST_CATCH) |=> (BUCK3_VOLTAGE_CODE == $past(DEFAULT_SELECT_CODE)))
    else $error("voltage code did not take the sensed default");

  chk_pulse_skip_wr: assert property (
    s_accepted_write |=> (PULSE_SKIP_ENABLE == $past(REG_WDATA[`BUCK3_PSE_BIT])))
    else $error("pulse-skip enable did not take the written bit");

  chk_code_write: assert property (
    s_accepted_write |=> (BUCK3_VOLTAGE_CODE == $past(REG_WDATA[`BUCK3_CODE_MSB:`BUCK3_CODE_LSB])))
    else $error("voltage code did not take the written value");

  chk_reserved_zero: assert property (
    REG_RVALID |-> !REG_RDATA[`BUCK3_RSV_BIT])
    else $error("reserved bit read as one");

  // sources and quiet cycles of the outputs
  chk_rvalid_source: assert property (
    REG_RVALID |-> $past(rd_hit))
    else $error("read answer without a read of the register");

  chk_unmapped_read: assert property (
    (REG_RD && !hit) |=> !REG_RVALID && (REG_RDATA == 8'h00))
    else $error("read of another subaddress was answered");

  chk_rdata_idle: assert property (
    !REG_RVALID |-> (REG_RDATA == 8'h00))
    else $error("read data not cleared outside a read answer");

  chk_refused_source: assert property (
    WRITE_REFUSED |-> $past(wr_refuse))
    else $error("refused flag raised without a locked write");

  chk_fields_held: assert property (
    (!wr_accept && !catching) |=> $stable(BUCK3_VOLTAGE_CODE) && $stable(PULSE_SKIP_ENABLE))
    else $error("register changed without an accepted write");

  chk_refused_no_blank: assert property (
    (wr_refuse && !MONITOR_BLANK) |=> !MONITOR_BLANK)
    else $error("locked write started monitor blanking");

  chk_blank_source: assert property (
    $rose(MONITOR_BLANK) |-> $past(wr_accept))
    else $error("monitor blanking started without an accepted write");

  chk_blank_restart: assert property (
    s_accepted_write |=> MONITOR_BLANK && (blank_len == '0))
    else $error("accepted write did not restart the blanking interval");

  chk_catch_quiet: assert property (
    (catching && REG_WR) |=> !WRITE_REFUSED && !MONITOR_BLANK)
    else $error("write during the default catch cycle took effect");

  chk_pse_catch_hold: assert property (
    catching |=> (PULSE_SKIP_ENABLE == `BUCK3_PSE_RESET))
    else $error("pulse-skip enable left its reset value in the catch cycle");

endmodule

//--- dv/host_model.sv
// host-side model: issues one-cycle register strobes on the control path
// assumes the bench calls access() and shares the clock with the register
`timescale 1ns/10ps
module host_model (
  // clock
  input  wire logic clk,
  // register request
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic       wr,
  output logic       rd,
  output logic       unlock
);
  // idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    unlock = 1'b0;
  end
  // one request for one cycle, then address and data go stale (inverted)
  task access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, input logic u);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    unlock <= u;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    unlock <= 1'b0;
  endtask
endmodule

//--- dv/buck3_voltage_control_reg_tb.sv
// self-checking bench for the buck3 control register
// assumes host_model drives the register strobes; blanking is shortened
`timescale 1ns/10ps
module buck3_voltage_control_reg_tb;
  localparam int BLANK = 20;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic wr, rd, unlock, rvalid, refused, pse, blank, u, e_pse;
  logic [7:0] addr, wdata, rdata, d;
  buck3_pkg::voltage_code_t dflt, code, e_code;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'hf8f5ddb4;
  int n;
  // clock of 4 ns
  always #2 CLOCK = ~CLOCK;
  host_model host (.clk(CLOCK), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .unlock(unlock));
  buck3_voltage_control_reg #(.BLANK_CYCLES(BLANK)) dut (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .WRITE_UNLOCK(unlock), .WRITE_REFUSED(refused),
    .DEFAULT_SELECT_CODE(dflt), .PULSE_SKIP_ENABLE(pse), .BUCK3_VOLTAGE_CODE(code), .MONITOR_BLANK(blank));
  // expected register image
  function automatic logic [7:0] exp_reg(input logic p, input logic [5:0] c);
    return {p, 1'b0, c};
  endfunction
  // byte compare
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // read and compare answer
  task rd_check(input logic [7:0] a, input logic [7:0] exp);
    host.access(1'b0, 1'b1, a, 8'h00, 1'b0);
    #1;
    chk({7'h00, rvalid}, {7'h00, a == 8'h18});
    chk(rdata, exp);
  endtask
  // count blanking cycles, bounded
  task blank_len;
    n = 0;
    while (blank === 1'b1 && n < 100) begin
      n++;
      @(posedge CLOCK);
      #1;
    end
    chk(8'(n), 8'(BLANK));
    if (n >= 100) finish_test;
  endtask
  // main sequence
  initial begin
    dflt = 6'($random(seed));
    repeat (2) @(posedge CLOCK);
    #1;
    chk({pse, 1'b0, code}, 8'h9F);
    chk({7'h00, blank}, 8'h00);
    // release on the third edge, with a write and a read landing in the catch cycle
    fork
      host.access(1'b1, 1'b1, 8'h18, 8'h00, 1'b1);
      @(posedge CLOCK) SYS_RST <= 1'b0;
    join
    #1;
    chk(rdata, 8'h9F);
    chk({6'h00, refused, blank}, 8'h00);
    e_pse = 1'b1;
    e_code = dflt;
    rd_check(8'h18, exp_reg(1'b1, dflt));
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'h40 : (i == 1) ? 8'hFF : 8'($random(seed));
      u = (i < 2) | 1'($random(seed));
      host.access(1'b1, 1'b0, 8'h18, d, u);
      #1;
      chk({7'h00, refused}, {7'h00, ~u});
      if (u) begin
        e_pse = d[7];
        e_code = d[5:0];
      end
      chk({pse, 1'b0, code}, exp_reg(e_pse, e_code));
      if (u) blank_len();
      else chk({7'h00, blank}, 8'h00);
      rd_check(8'h18, exp_reg(e_pse, e_code));
    end
    host.access(1'b1, 1'b0, 8'h19, 8'h00, 1'b1);
    rd_check(8'h19, 8'h00);
    rd_check(8'h18, exp_reg(e_pse, e_code));
    finish_test;
  end
endmodule
